// ===== hw/owd_pkg.sv
`default_nettype none
package owd_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned DEC_PERIOD_CYC = 3072;
  localparam int unsigned TIMEOUT_STEPS = 64;
  localparam int unsigned REF_OSC_HZ = 8_000_000;
  localparam int unsigned DEC_TIME_US_REF = 384;
  localparam int unsigned DEC_TIME_US_CALC = (DEC_PERIOD_CYC * 1000) / (REF_OSC_HZ / 1000);
  localparam int unsigned RST_PULSE_NS = 500;
  localparam int unsigned RST_PULSE_CYC_RAW = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_PULSE_CYC = (RST_PULSE_CYC_RAW < 1) ? 1 : RST_PULSE_CYC_RAW;

  // ------------------------------------------------------------
  // watchdog_count_register layout
  // ------------------------------------------------------------
  localparam int unsigned CNT_W = 7;
  localparam int unsigned PSC_W = 12;
  localparam int unsigned PULSE_W = 5;
  localparam int unsigned BIT_ACT = 0;
  localparam int unsigned BIT_TOP = 1;
  localparam int unsigned BIT_T_LO = 2;
  localparam int unsigned BIT_T_HI = 7;
  localparam logic [7:0] WDG_RESET_VAL = 8'hFE;
  localparam logic [CNT_W-1:0] CNT_RESET_VAL = 7'h7F;
  localparam logic [PSC_W-1:0] PSC_LAST = 12'(DEC_PERIOD_CYC - 1);
  localparam logic [PULSE_W-1:0] PULSE_LOAD = 5'(RST_PULSE_CYC);

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    OWD_PM_RUN  = 2'b00,
    OWD_PM_WAIT = 2'b01,
    OWD_PM_STOP = 2'b10
  } owd_pm_e;

  typedef struct packed {
    logic en;
    logic [7:0] data;
  } owd_wr_s;

  typedef struct packed {
    logic stop_instr;
    logic wait_instr;
    logic wake;
  } owd_pm_req_s;

endpackage
`default_nettype wire

// ===== hw/owd_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module owd_watchdog
  import owd_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic activation_option_in,
  input wire logic external_stop_gate_option_in,
  input wire logic nmi_in,
  input wire owd_wr_s wr_in,
  input wire owd_pm_req_s pm_req_in,
  output logic [7:0] watchdog_count_register_out,
  output logic wdg_active_out,
  output logic rst_pin_n_out,
  output logic wait_mode_out,
  output logic stop_mode_out
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [CNT_W-1:0] cnt_ff;
  logic act_ff;
  logic [PSC_W-1:0] psc_ff;
  logic [PULSE_W-1:0] pulse_ff;
  owd_pm_e pm_ff;
  owd_pm_e nxt_pm;
  logic pulsing;
  logic tick;
  logic running;
  logic wr_act;
  logic [CNT_W-1:0] wr_cnt;
  logic expire;

  assign pulsing = (pulse_ff != '0);
  // 3072 core cycles per step, 384 us at 8 MHz
  assign tick = (psc_ff == PSC_LAST);
  // stop freezes counting; wait has no effect on it
  assign running = (pm_ff != OWD_PM_STOP);
  assign wr_act = act_ff | wr_in.data[BIT_ACT] | activation_option_in;

  // register bits 7:2 carry count bits 0..5, bit 1 the top bit
  for (genvar g = 0; g < CNT_W - 1; g++) begin : g_wr_cnt
    assign wr_cnt[g] = wr_in.data[BIT_T_HI - g];
  end
  assign wr_cnt[CNT_W-1] = wr_in.data[BIT_TOP];

  // active with top bit clear starts the reset cycle
  assign expire = act_ff & ~cnt_ff[CNT_W-1] & ~pulsing;

  // ------------------------------------------------------------
  // prescaler: one decrement period
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      psc_ff <= '0;
    end else if (clk_en_in) begin
      if (pulsing || wr_in.en) begin
        psc_ff <= '0;
      end else if (running) begin
        psc_ff <= tick ? '0 : psc_ff + 12'h001;
      end
    end
  end

  // ------------------------------------------------------------
  // downcounter
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_ff <= CNT_RESET_VAL;
    end else if (clk_en_in) begin
      if (pulsing) begin
        cnt_ff <= CNT_RESET_VAL;
      end else if (wr_in.en) begin
        cnt_ff <= wr_cnt;
      end else if (running && tick) begin
        // wraps freely when used as a timer
        cnt_ff <= cnt_ff - 7'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // activate bit
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      act_ff <= 1'b0;
    end else if (clk_en_in) begin
      if (activation_option_in) begin
        act_ff <= 1'b1;
      end else if (pulsing) begin
        act_ff <= 1'b0;
      end else if (wr_in.en) begin
        act_ff <= wr_act;
      end
    end
  end

  // ------------------------------------------------------------
  // reset pulse
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pulse_ff <= '0;
    end else if (clk_en_in) begin
      if (expire) begin
        pulse_ff <= PULSE_LOAD;
      end else if (pulsing) begin
        pulse_ff <= pulse_ff - 5'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // low power modes
  // ------------------------------------------------------------
  always_comb begin
    nxt_pm = pm_ff;
    unique case (pm_ff)
      OWD_PM_RUN: begin
        if (pm_req_in.stop_instr) begin
          if (!act_ff) begin
            nxt_pm = OWD_PM_STOP;
          end else if (!external_stop_gate_option_in || !nmi_in) begin
            nxt_pm = OWD_PM_WAIT;
          end else begin
            nxt_pm = OWD_PM_STOP;
          end
        end else if (pm_req_in.wait_instr) begin
          nxt_pm = OWD_PM_WAIT;
        end
      end
      OWD_PM_WAIT: begin
        if (pm_req_in.wake) begin
          nxt_pm = OWD_PM_RUN;
        end
      end
      OWD_PM_STOP: begin
        if (pm_req_in.wake) begin
          nxt_pm = OWD_PM_RUN;
        end
      end
      default: begin
        nxt_pm = OWD_PM_RUN;
      end
    endcase
    if (pulsing) begin
      nxt_pm = OWD_PM_RUN;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pm_ff <= OWD_PM_RUN;
    end else if (clk_en_in) begin
      pm_ff <= nxt_pm;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // activate bit reads back the held flag, which may lag the option
  assign watchdog_count_register_out = {cnt_ff[0], cnt_ff[1], cnt_ff[2], cnt_ff[3], cnt_ff[4],
                                        cnt_ff[5], cnt_ff[CNT_W-1], act_ff};
  assign wdg_active_out = act_ff;
  assign rst_pin_n_out = ~pulsing;
  assign wait_mode_out = (pm_ff == OWD_PM_WAIT);
  assign stop_mode_out = (pm_ff == OWD_PM_STOP);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  dec_period_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && tick && running && !wr_in.en && !pulsing
    |=> cnt_ff == $past(cnt_ff) - 7'h01)
    else $error("count did not step on period end");

  psc_limit_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    psc_ff <= PSC_LAST)
    else $error("prescaler ran past its period");

  hw_force_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && activation_option_in |=> act_ff)
    else $error("hardware option left watchdog inactive");

  sw_sticky_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    act_ff && !pulsing |=> act_ff)
    else $error("activate bit cleared without reset");

  expire_pulse_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in || !clk_en_in)
    act_ff && !cnt_ff[CNT_W-1] && rst_pin_n_out |=> !rst_pin_n_out [*8])
    else $error("expiry gave no reset pulse");

  pulse_len_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $rose(pulse_ff == PULSE_LOAD) |-> pulse_ff == 5'd13)
    else $error("reset pulse length wrong");

  sw_reset_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in || !clk_en_in)
    wr_in.en && !wr_in.data[BIT_TOP] && wr_act && !pulsing |-> ##2 !rst_pin_n_out)
    else $error("software reset not generated");

  write_back_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && wr_in.en && !pulsing
    |=> watchdog_count_register_out[7:1] == $past(wr_in.data[7:1]) && psc_ff == '0)
    else $error("write not reflected in register");

  stop_as_wait_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && pm_ff == OWD_PM_RUN && pm_req_in.stop_instr && act_ff && !pulsing
    && (!external_stop_gate_option_in || !nmi_in) |=> wait_mode_out && !stop_mode_out)
    else $error("stop not turned into wait");

  stop_enter_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && pm_ff == OWD_PM_RUN && pm_req_in.stop_instr && !pulsing
    && (!act_ff || (external_stop_gate_option_in && nmi_in)) |=> stop_mode_out)
    else $error("stop mode not entered");

  stop_freeze_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    stop_mode_out && !wr_in.en && !pulsing |=> $stable(cnt_ff))
    else $error("counter moved in stop mode");

  wait_count_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && wait_mode_out && !pulsing && !wr_in.en && psc_ff != PSC_LAST |=> psc_ff == $past(psc_ff) + 12'h001)
    else $error("prescaler halted in wait mode");

  sw_activate_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && wr_in.en && wr_in.data[BIT_ACT] && !pulsing |=> act_ff)
    else $error("activate write not taken");

  sw_idle_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !activation_option_in && !act_ff && !(clk_en_in && wr_in.en && wr_in.data[BIT_ACT]) |=> !act_ff)
    else $error("watchdog activated without a write");

  pulse_cause_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $fell(rst_pin_n_out) |-> $past(act_ff) && !$past(cnt_ff[CNT_W-1]))
    else $error("reset pulse without expiry");

  pulse_step_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && pulsing |=> pulse_ff == $past(pulse_ff) - 5'h01)
    else $error("reset pulse counter skipped");

  pulse_reload_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && pulsing |=> cnt_ff == CNT_RESET_VAL && psc_ff == '0)
    else $error("count not reloaded during reset pulse");

  pulse_run_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && pulsing |=> pm_ff == OWD_PM_RUN)
    else $error("low power mode kept during reset pulse");

  top_set_quiet_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    act_ff && cnt_ff[CNT_W-1] && !pulsing |=> rst_pin_n_out)
    else $error("reset pulse with top bit set");

  timer_quiet_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !act_ff && !pulsing |=> rst_pin_n_out)
    else $error("reset pulse while used as timer");

  count_hold_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && !tick && !wr_in.en && !pulsing |=> $stable(cnt_ff))
    else $error("count moved inside a period");

  psc_step_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && running && !tick && !wr_in.en && !pulsing |=> psc_ff == $past(psc_ff) + 12'h001)
    else $error("prescaler did not advance");

  wait_enter_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && pm_ff == OWD_PM_RUN && pm_req_in.wait_instr && !pm_req_in.stop_instr && !pulsing
    |=> wait_mode_out)
    else $error("wait mode not entered");

  wake_run_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && pm_ff != OWD_PM_RUN && pm_req_in.wake |=> !wait_mode_out && !stop_mode_out)
    else $error("wake did not return to run");

  stop_hold_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    stop_mode_out && !wr_in.en && !pulsing |=> $stable(psc_ff))
    else $error("prescaler moved in stop mode");

endmodule // owd_watchdog
`default_nettype wire

// ===== verif/owd_rst_mon.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// reset circuitry model: low pulse width
// ----------------------------------------
module owd_rst_mon (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic rst_pin_n_in,
  output logic [7:0] low_len_out,
  output logic [7:0] pulse_cnt_out
);
  logic [7:0] run_ff;
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      run_ff <= 8'h00;
      low_len_out <= 8'h00;
      pulse_cnt_out <= 8'h00;
    end else if (!rst_pin_n_in) begin
      run_ff <= run_ff + 8'h01;
    end else if (run_ff != 8'h00) begin
      low_len_out <= run_ff;
      pulse_cnt_out <= pulse_cnt_out + 8'h01;
      run_ff <= 8'h00;
    end
  end
endmodule // owd_rst_mon
`default_nettype wire

// ===== verif/option_selectable_watchdog_bench.sv
`timescale 1ns/1ps
`default_nettype none
module option_selectable_watchdog_bench;
  import owd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cen = 1'b1;
  logic hw = 1'b0;
  logic gate = 1'b0;
  logic nmi = 1'b1;
  owd_wr_s wr = '0;
  owd_pm_req_s pm = '0;
  logic [7:0] wreg, len, pcnt;
  logic act, rn, wm, sm;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  owd_watchdog uut (.core_clk_in(clk), .sys_rst_in(rst), .clk_en_in(cen),
    .activation_option_in(hw), .external_stop_gate_option_in(gate), .nmi_in(nmi),
    .wr_in(wr), .pm_req_in(pm), .watchdog_count_register_out(wreg),
    .wdg_active_out(act), .rst_pin_n_out(rn), .wait_mode_out(wm), .stop_mode_out(sm));
  owd_rst_mon mon (.core_clk_in(clk), .sys_rst_in(rst), .rst_pin_n_in(rn),
    .low_len_out(len), .pulse_cnt_out(pcnt));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] enc(input logic [6:0] c, input logic a);
    enc = {c[0], c[1], c[2], c[3], c[4], c[5], c[6], a};
  endfunction
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wrr(input logic [7:0] d);
    @(posedge clk);
    wr <= '{en: 1'b1, data: d};
    @(posedge clk);
    wr <= '0;
    @(negedge clk);
  endtask
  task automatic pmr(input owd_pm_req_s p);
    @(posedge clk);
    pm <= p;
    @(posedge clk);
    pm <= '0;
    tick(1);
  endtask
  task automatic do_rst(input logic h, input logic g);
    @(posedge clk);
    hw <= h;
    gate <= g;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    tick(2);
  endtask
  task automatic wait_low(input int n);
    for (int i = 0; i < n && rn !== 1'b0; i++) @(negedge clk);
    chk({7'h0, rn}, 8'h00);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  localparam owd_pm_req_s STP = '{stop_instr: 1'b1, wait_instr: 1'b0, wake: 1'b0};
  localparam owd_pm_req_s WTI = '{stop_instr: 1'b0, wait_instr: 1'b1, wake: 1'b0};
  localparam owd_pm_req_s WAK = '{stop_instr: 1'b0, wait_instr: 1'b0, wake: 1'b1};
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    chk(wreg, 8'hFE);
    chk({6'h0, act, rn}, 8'h01);
    chk({6'h0, wm, sm}, 8'h00);
    // refresh values stay in FEh..02h with top bit set
    wrr(enc(7'h40, 1'b0));
    chk(wreg, 8'h02);
    tick(3060);
    chk(wreg, 8'h02);
    tick(16);
    chk(wreg, enc(7'h3F, 1'b0));
    chk({7'h0, rn}, 8'h01);
    tick(1);
    chk(wreg, enc(7'h3F, 1'b0));
    pmr(WTI);
    chk({7'h0, wm}, 8'h01);
    tick(3080);
    chk(wreg, enc(7'h3E, 1'b0));
    pmr(WAK);
    pmr(STP);
    chk({6'h0, wm, sm}, 8'h01);
    pmr(WAK);
    wrr(enc(7'h40, 1'b1));
    wait_low(3100);
    tick(20);
    chk(len, 8'(RST_PULSE_CYC));
    chk(wreg, 8'hFE);
    chk({7'h0, act}, 8'h00);
    wrr(8'hFF);
    wrr(8'hFD);
    wait_low(3);
    tick(20);
    chk(pcnt, 8'h02);
    wrr(8'hFF);
    wrr(8'hFE);
    chk({7'h0, act}, 8'h01);
    pmr(STP);
    chk({6'h0, wm, sm}, 8'h02);
    pmr(WAK);
    do_rst(1'b0, 1'b1);
    wrr(8'hFF);
    @(posedge clk);
    nmi <= 1'b0;
    pmr(STP);
    chk({6'h0, wm, sm}, 8'h02);
    pmr(WAK);
    @(posedge clk);
    nmi <= 1'b1;
    wrr(8'hFF);
    pmr(STP);
    chk({6'h0, wm, sm}, 8'h01);
    tick(4000);
    chk(wreg, 8'hFF);
    pmr(WAK);
    tick(3080);
    chk(wreg, enc(7'h7E, 1'b1));
    do_rst(1'b1, 1'b0);
    chk({7'h0, act}, 8'h01);
    wrr(8'hFE);
    chk(wreg, 8'hFF);
    @(posedge clk);
    cen <= 1'b0;
    wrr(8'hFD);
    tick(5);
    chk({7'h0, rn}, 8'h01);
    chk(wreg, 8'hFF);
    @(posedge clk);
    cen <= 1'b1;
    end_of_test();
  end
endmodule // option_selectable_watchdog_bench
`default_nettype wire
